// ---- hdl/pcpa_map.svh ----
/*
 offsets, field positions and reset values of the prescale and alignment registers.
 assumes byte-wide register port with byte offsets from the module base.
*/
`ifndef PCPA_MAP_SVH
`define PCPA_MAP_SVH
`define PCPA_OFF_PRESCALE   8'h03
`define PCPA_OFF_ALIGN      8'h04
`define PCPA_OFF_CHAN_SEL   8'h06
`define PCPA_OFF_ALIGN_MON  8'h07
`define PCPA_CLK_A_SEL_LSB  0
`define PCPA_CLK_B_SEL_LSB  4
`define PCPA_RST_PRESCALE   8'h00
`define PCPA_RST_ALIGN      8'h00
`define PCPA_RST_CHAN_SEL   8'h00
`define PCPA_PRESCALE_MASK  8'h77
`endif

// ---- hdl/pcpa_pkg.sv ----
/*
 types shared by the prescale and alignment block.
 assumes nothing beyond a systemverilog compiler.
*/
package pcpa_pkg;
   typedef logic [2:0] pcpa_div_sel_t;
   typedef logic [6:0] pcpa_count_t;
   typedef logic [7:0] pcpa_byte_t;
   typedef enum logic [0:0] {
      PCPA_LEFT   = 1'b0,
      PCPA_CENTER = 1'b1
   } pcpa_align_e;
endpackage : pcpa_pkg

// ---- hdl/pcpa_prescaler.sv ----
/*
 free-running prescaler producing a one-cycle enable at bus clock / 2**sel.
 assumes synchronous active-low reset and a single bus clock.
*/
`timescale 1ns/10ps
module pcpa_prescaler (
   // clock and reset
   input  wire logic                   clk_sys_in,
   input  wire logic                   rstn_in,
   // divider control
   input  wire pcpa_pkg::pcpa_count_t  count_in,
   input  wire pcpa_pkg::pcpa_div_sel_t sel_in,
   // enable pulse
   output logic                        tick_out
);
   logic [6:0] mask;
   logic       next_tick;

   assign mask      = 7'((8'h01 << sel_in) - 8'h01);
   assign next_tick = ((count_in & mask) == 7'h00);

   always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         tick_out <= 1'b0;
      end else begin
         tick_out <= next_tick;
      end
   end
endmodule : pcpa_prescaler

// ---- hdl/pcpa_top.sv ----
/*
 prescaled clock a/b enables, channel clock source and alignment controls.
 assumes byte register port, one 100 mhz bus clock, synchronous reset.
*/
`timescale 1ns/10ps
`include "pcpa_map.svh"

module pcpa_top (
   // clock and reset
   input  wire logic        clk_sys_in,
   input  wire logic        rstn_in,
   // register port
   input  wire logic [7:0]  addr_in,
   input  wire logic [7:0]  wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic      [7:0]  rdata_out,
   // clock enables
   output logic             clk_a_tick_out,
   output logic             clk_b_tick_out,
   output logic      [7:0]  chan_tick_out,
   // alignment controls
   output logic      [7:0]  chan_center_align_out
);
   logic [6:0] count;
   logic [7:0] clock_prescale_select;
   logic [7:0] center_align_enable;
   logic [7:0] chan_clk_sel;
   logic       tick_a;
   logic       tick_b;
   logic       hit_pre;
   logic       hit_align;
   logic       hit_sel;
   logic       hit_mon;
   logic [7:0] next_rdata;
   logic [7:0] next_chan_tick;
   pcpa_pkg::pcpa_div_sel_t clk_a_div_sel;
   pcpa_pkg::pcpa_div_sel_t clk_b_div_sel;

   assign clk_a_div_sel = clock_prescale_select[`PCPA_CLK_A_SEL_LSB +: 3];
   assign clk_b_div_sel = clock_prescale_select[`PCPA_CLK_B_SEL_LSB +: 3];

   // low count bits that must be zero for a tick at this select code
   function automatic logic [6:0] div_mask(input pcpa_pkg::pcpa_div_sel_t sel);
      return 7'((8'h01 << sel) - 8'h01);
   endfunction : div_mask

   assign hit_pre   = (addr_in == `PCPA_OFF_PRESCALE);
   assign hit_align = (addr_in == `PCPA_OFF_ALIGN);
   assign hit_sel   = (addr_in == `PCPA_OFF_CHAN_SEL);
   assign hit_mon   = (addr_in == `PCPA_OFF_ALIGN_MON);

   assign next_rdata = !rd_in     ? 8'h00 :
                       hit_pre    ? clock_prescale_select :
                       hit_align  ? center_align_enable :
                       hit_sel    ? chan_clk_sel :
                       hit_mon    ? chan_center_align_out :
                       8'h00;

   always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         count <= 7'h00;
      end else begin
         count <= count + 7'h01;
      end
   end

   pcpa_prescaler u_pre_a (
      .clk_sys_in (clk_sys_in),
      .rstn_in    (rstn_in),
      .count_in   (count),
      .sel_in     (clk_a_div_sel),
      .tick_out   (tick_a)
   );

   pcpa_prescaler u_pre_b (
      .clk_sys_in (clk_sys_in),
      .rstn_in    (rstn_in),
      .count_in   (count),
      .sel_in     (clk_b_div_sel),
      .tick_out   (tick_b)
   );

   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_chan
         assign next_chan_tick[g] = chan_clk_sel[g] ? tick_b : tick_a;
      end
   endgenerate

   always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         clock_prescale_select <= `PCPA_RST_PRESCALE;
         center_align_enable   <= `PCPA_RST_ALIGN;
         chan_clk_sel          <= `PCPA_RST_CHAN_SEL;
      end else if (wr_in) begin
         if (hit_pre) begin
            clock_prescale_select <= wdata_in & `PCPA_PRESCALE_MASK;
         end else if (hit_align) begin
            center_align_enable <= wdata_in;
         end else if (hit_sel) begin
            chan_clk_sel <= wdata_in;
         end
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         rdata_out             <= 8'h00;
         clk_a_tick_out        <= 1'b0;
         clk_b_tick_out        <= 1'b0;
         chan_tick_out         <= 8'h00;
         chan_center_align_out <= `PCPA_RST_ALIGN;
      end else begin
         rdata_out             <= next_rdata;
         clk_a_tick_out        <= tick_a;
         clk_b_tick_out        <= tick_b;
         chan_tick_out         <= next_chan_tick;
         chan_center_align_out <= center_align_enable;
      end
   end

   property p_a_single;
      @(posedge clk_sys_in) disable iff (!rstn_in)
      (clk_a_div_sel == 3'h1 && $stable(clk_a_div_sel) && tick_a) |=> !tick_a;
   endproperty
   a_a_single: assert property (p_a_single) else $error("clock a tick repeated");

   property p_a_128;
      @(posedge clk_sys_in) disable iff (!rstn_in)
      (clk_a_div_sel == 3'h7 && $stable(clk_a_div_sel) && tick_a) |-> (count == 7'h01);
   endproperty
   a_a_128: assert property (p_a_128) else $error("clock a off by 128");

   property p_a_pass;
      @(posedge clk_sys_in) disable iff (!rstn_in)
      (rstn_in && clk_a_div_sel == 3'h0) ##1 (clk_a_div_sel == 3'h0) |-> tick_a;
   endproperty
   a_a_pass: assert property (p_a_pass) else $error("clock a bypass lost");

   property p_b_ratio;
      @(posedge clk_sys_in) disable iff (!rstn_in)
      (clk_b_div_sel == 3'h2 && $stable(clk_b_div_sel) && tick_b) |-> (count[1:0] == 2'h1);
   endproperty
   a_b_ratio: assert property (p_b_ratio) else $error("clock b wrong ratio");

   property p_src;
      @(posedge clk_sys_in) disable iff (!rstn_in)
      ##1 (chan_tick_out[0] == ($past(chan_clk_sel[0]) ? clk_b_tick_out : clk_a_tick_out));
   endproperty
   a_src: assert property (p_src) else $error("channel 0 source wrong");

   property p_align_wr;
      @(posedge clk_sys_in) disable iff (!rstn_in)
      (wr_in && addr_in == `PCPA_OFF_ALIGN) |->
         ##2 (chan_center_align_out == $past(wdata_in, 2));
   endproperty
   a_align_wr: assert property (p_align_wr) else $error("align write lost");

   property p_rd_align;
      @(posedge clk_sys_in) disable iff (!rstn_in)
      (rd_in && addr_in == `PCPA_OFF_ALIGN) |=> (rdata_out == $past(center_align_enable));
   endproperty
   a_rd_align: assert property (p_rd_align) else $error("align readback wrong");

   property p_align_hold;
      @(posedge clk_sys_in) disable iff (!rstn_in)
      !(wr_in && hit_align) |=> $stable(center_align_enable);
   endproperty
   a_align_hold: assert property (p_align_hold) else $error("align bits changed");

   property p_a_exact;
      @(posedge clk_sys_in) disable iff (!rstn_in)
      ($past(rstn_in) && $stable(clk_a_div_sel)) |->
         (tick_a == (((count - 7'h01) & div_mask(clk_a_div_sel)) == 7'h00));
   endproperty
   a_a_exact: assert property (p_a_exact) else $error("clock a tick phase wrong");

   property p_b_exact;
      @(posedge clk_sys_in) disable iff (!rstn_in)
      ($past(rstn_in) && $stable(clk_b_div_sel)) |->
         (tick_b == (((count - 7'h01) & div_mask(clk_b_div_sel)) == 7'h00));
   endproperty
   a_b_exact: assert property (p_b_exact) else $error("clock b tick phase wrong");

   property p_b_pass;
      @(posedge clk_sys_in) disable iff (!rstn_in)
      (rstn_in && clk_b_div_sel == 3'h0) ##1 (clk_b_div_sel == 3'h0) |-> tick_b;
   endproperty
   a_b_pass: assert property (p_b_pass) else $error("clock b bypass lost");

   property p_src7;
      @(posedge clk_sys_in) disable iff (!rstn_in)
      ##1 (chan_tick_out[7] == ($past(chan_clk_sel[7]) ? clk_b_tick_out : clk_a_tick_out));
   endproperty
   a_src7: assert property (p_src7) else $error("channel 7 source wrong");

   property p_count_step;
      @(posedge clk_sys_in) disable iff (!rstn_in)
      $past(rstn_in) |-> (count == $past(count) + 7'h01);
   endproperty
   a_count_step: assert property (p_count_step) else $error("divider count skipped");

   property p_pre_wr;
      @(posedge clk_sys_in) disable iff (!rstn_in)
      (wr_in && hit_pre) |=>
         (clock_prescale_select == ($past(wdata_in) & `PCPA_PRESCALE_MASK));
   endproperty
   a_pre_wr: assert property (p_pre_wr) else $error("select write lost");

   property p_pre_bits;
      @(posedge clk_sys_in) disable iff (!rstn_in)
      (clock_prescale_select & ~`PCPA_PRESCALE_MASK) == 8'h00;
   endproperty
   a_pre_bits: assert property (p_pre_bits) else $error("select reserved bit set");

   property p_pre_hold;
      @(posedge clk_sys_in) disable iff (!rstn_in)
      !(wr_in && hit_pre) |=> $stable(clock_prescale_select);
   endproperty
   a_pre_hold: assert property (p_pre_hold) else $error("select changed");

   property p_sel_wr;
      @(posedge clk_sys_in) disable iff (!rstn_in)
      (wr_in && hit_sel) |=> (chan_clk_sel == $past(wdata_in));
   endproperty
   a_sel_wr: assert property (p_sel_wr) else $error("source write lost");

   property p_sel_hold;
      @(posedge clk_sys_in) disable iff (!rstn_in)
      !(wr_in && hit_sel) |=> $stable(chan_clk_sel);
   endproperty
   a_sel_hold: assert property (p_sel_hold) else $error("source changed");

   property p_rd_pre;
      @(posedge clk_sys_in) disable iff (!rstn_in)
      (rd_in && hit_pre) |=> (rdata_out == $past(clock_prescale_select));
   endproperty
   a_rd_pre: assert property (p_rd_pre) else $error("select readback wrong");

   property p_rd_sel;
      @(posedge clk_sys_in) disable iff (!rstn_in)
      (rd_in && hit_sel) |=> (rdata_out == $past(chan_clk_sel));
   endproperty
   a_rd_sel: assert property (p_rd_sel) else $error("source readback wrong");

   property p_rd_mon;
      @(posedge clk_sys_in) disable iff (!rstn_in)
      (rd_in && hit_mon) |=> (rdata_out == $past(chan_center_align_out));
   endproperty
   a_rd_mon: assert property (p_rd_mon) else $error("monitor readback wrong");

   property p_rd_none;
      @(posedge clk_sys_in) disable iff (!rstn_in)
      (rd_in && !hit_pre && !hit_align && !hit_sel && !hit_mon) |=> (rdata_out == 8'h00);
   endproperty
   a_rd_none: assert property (p_rd_none) else $error("unmapped read not zero");

   property p_rd_idle;
      @(posedge clk_sys_in) disable iff (!rstn_in)
      !rd_in |=> (rdata_out == 8'h00);
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not cleared");

   generate
      for (g = 0; g < 8; g++) begin : g_align
         property p_chan_align;
            @(posedge clk_sys_in) disable iff (!rstn_in)
            $past(rstn_in) |-> (chan_center_align_out[g] == $past(center_align_enable[g]));
         endproperty
         a_chan_align: assert property (p_chan_align) else $error("channel align wrong");
      end
   endgenerate
endmodule : pcpa_top

// ---- verification/pcpa_top_bench.sv ----
/*
 self-checking bench for pcpa_top: register port, prescaled ticks, alignment.
 assumes the hdl files are compiled first and the register port of the notes.
*/
`timescale 1ns/10ps
module pcpa_top_bench;
   logic       clk_sys_in = 1'b0;
   logic       rstn_in    = 1'b0;
   logic [7:0] addr_in    = 8'h00;
   logic [7:0] wdata_in   = 8'h00;
   logic       wr_in      = 1'b0;
   logic       rd_in      = 1'b0;
   logic [7:0] rdata_out;
   logic [7:0] chan_tick_out;
   logic [7:0] chan_center_align_out;
   logic       clk_a_tick_out;
   logic       clk_b_tick_out;
   int         miscompares = 0;
   int         check_count = 0;

   pcpa_top dut_u (
      .clk_sys_in            (clk_sys_in),
      .rstn_in               (rstn_in),
      .addr_in               (addr_in),
      .wdata_in              (wdata_in),
      .wr_in                 (wr_in),
      .rd_in                 (rd_in),
      .rdata_out             (rdata_out),
      .clk_a_tick_out        (clk_a_tick_out),
      .clk_b_tick_out        (clk_b_tick_out),
      .chan_tick_out         (chan_tick_out),
      .chan_center_align_out (chan_center_align_out)
   );

   always #5 clk_sys_in = ~clk_sys_in;

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_in);
      addr_in  <= a;
      wdata_in <= d;
      wr_in    <= 1'b1;
      @(posedge clk_sys_in);
      wr_in    <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      @(posedge clk_sys_in);
      addr_in <= a;
      rd_in   <= 1'b1;
      @(posedge clk_sys_in);
      rd_in   <= 1'b0;
      @(negedge clk_sys_in);
      check(what, exp, rdata_out);
      @(negedge clk_sys_in);
      check("read data idle", 8'h00, rdata_out);
   endtask : rd

   function automatic logic tick(input logic b);
      return b ? clk_b_tick_out : clk_a_tick_out;
   endfunction : tick

   // cycles between two successive ticks of clock a or b
   task automatic period(input logic b, input int exp);
      int n;
      repeat (3) @(negedge clk_sys_in);
      for (n = 0; n < 300 && tick(b) !== 1'b1; n++) @(negedge clk_sys_in);
      @(negedge clk_sys_in);
      for (n = 1; n < 300 && tick(b) !== 1'b1; n++) @(negedge clk_sys_in);
      check("tick period", exp[7:0], n[7:0]);
   endtask : period

   task automatic test_regs();
      rd(8'h03, 8'h00, "prescale reset");
      rd(8'h04, 8'h00, "align reset");
      wr(8'h04, 8'h5a);
      repeat (2) @(negedge clk_sys_in);
      check("align out", 8'h5a, chan_center_align_out);
      rd(8'h04, 8'h5a, "align read");
      wr(8'h04, 8'ha5);
      repeat (2) @(negedge clk_sys_in);
      check("align out", 8'ha5, chan_center_align_out);
      rd(8'h07, 8'ha5, "align monitor");
      wr(8'h07, 8'h00);
      rd(8'h07, 8'ha5, "monitor read only");
      wr(8'h03, 8'hff);
      rd(8'h03, 8'h77, "prescale mask");
      wr(8'h10, 8'hff);
      rd(8'h10, 8'h00, "unmapped read");
      rd(8'h04, 8'ha5, "align after unmapped write");
   endtask : test_regs

   task automatic test_ratios();
      for (int s = 0; s < 8; s++) begin
         wr(8'h03, {1'b0, 3'(7 - s), 1'b0, 3'(s)});
         period(1'b0, 1 << s);
         period(1'b1, 1 << (7 - s));
      end
   endtask : test_ratios

   // channels 0..3 on clock b at /4, channels 4..7 on clock a at /2
   task automatic test_chan_src();
      int na;
      int nb;
      int nc0;
      int nc7;
      int nbad;
      na = 0;
      nb = 0;
      nc0 = 0;
      nc7 = 0;
      nbad = 0;
      wr(8'h06, 8'h0f);
      wr(8'h03, 8'h21);
      rd(8'h06, 8'h0f, "chan select read");
      repeat (4) @(negedge clk_sys_in);
      repeat (64) begin
         @(negedge clk_sys_in);
         na += (clk_a_tick_out === 1'b1);
         nb += (clk_b_tick_out === 1'b1);
         nc0 += (chan_tick_out[0] === 1'b1);
         nc7 += (chan_tick_out[7] === 1'b1);
         nbad += (chan_tick_out !== {{4{clk_a_tick_out}}, {4{clk_b_tick_out}}});
      end
      check("chan ticks all", 8'd0, nbad[7:0]);
      check("ticks a", 8'd32, na[7:0]);
      check("ticks b", 8'd16, nb[7:0]);
      check("chan 0 on b", 8'd16, nc0[7:0]);
      check("chan 7 on a", 8'd32, nc7[7:0]);
   endtask : test_chan_src

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : print_verdict

   initial begin
      #200us;
      miscompares++;
      print_verdict();
   end

   initial begin
      repeat (12) @(posedge clk_sys_in);
      rstn_in <= 1'b1;
      test_regs();
      test_ratios();
      test_chan_src();
      print_verdict();
   end
endmodule : pcpa_top_bench
